// ---- scr_pkg.sv ----
// Package for the first system control register block
package scr_pkg;
    // ************************************************
    // Register map
    // ************************************************
    localparam logic [7:0] ADDR_VOLTAGE_SELECT = 8'h00;
    localparam logic [7:0] ADDR_SYSTEM_CONTROL_ONE = 8'h01;
    localparam int BIT_RUN = 7;
    localparam int BIT_SCALE_AUTH = 6;
    localparam int SLEW_MSB = 5;
    localparam int SLEW_LSB = 3;
    localparam int BIT_OV_RETRY = 2;
    localparam int BIT_OC_HICCUP = 1;
    localparam int BIT_LIGHT_MODE = 0;
    localparam int BIT_FB_SELECT = 7;
    localparam logic [7:0] RESET_SYSTEM_CONTROL_ONE = 8'ha6;
    localparam logic [7:0] RESET_VOLTAGE_SELECT = 8'h9e;
    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int HICCUP_OFF_US = 100;
    localparam int HICCUP_OFF_CYCLES = (HICCUP_OFF_US * 1000) / CLK_PERIOD_NS;
    localparam logic [11:0] SLEW_BASE_CYCLES = 12'h010;

    typedef struct packed {
        logic run;
        logic scale_auth;
        logic [2:0] slew;
        logic ov_retry;
        logic oc_hiccup;
        logic light_mode;
    } scr_ctrl_type;

    typedef struct packed {
        logic fb_select;
        logic [6:0] ref_code;
    } scr_vsel_type;

    typedef enum logic [1:0] {
        SCR_RUN = 2'b00,
        SCR_HICCUP = 2'b01,
        SCR_LATCHED = 2'b11
    } scr_prot_type;
endpackage

// ---- scr_system_control.sv ----
// First system control register with scaling, mode and protection logic
`timescale 1ns/1ns
module scr_system_control (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic enable_pin,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    input wire logic overvoltage,
    input wire logic overcurrent,
    input wire logic undervoltage,
    output logic high_side_switch,
    output logic low_side_switch,
    output logic forced_pwm,
    output logic feedback_from_divider,
    output logic [6:0] output_voltage,
    output logic bus_active
);
    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic en_s1_q;
    logic en_s2_q;
    logic en_on;
    logic ov_in;
    logic oc_in;
    logic uv_in;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= {overvoltage, overcurrent, undervoltage};
            pin_s2_q <= pin_s1_q;
            en_s1_q <= enable_pin;
            en_s2_q <= en_s1_q;
        end
    end

    assign en_on = en_s2_q;
    assign ov_in = pin_s2_q[2];
    assign oc_in = pin_s2_q[1];
    assign uv_in = pin_s2_q[0];

    // ************************************************
    // Registers and ramp
    // ************************************************
    scr_pkg::scr_ctrl_type ctrl_q, ctrl_d;
    scr_pkg::scr_vsel_type vsel_q, vsel_d;
    logic [6:0] ramp_q, ramp_d;
    logic [11:0] step_cnt_q, step_cnt_d;
    logic [11:0] step_len;
    logic [7:0] rd_data_d;
    logic ramping;

    assign step_len = scr_pkg::SLEW_BASE_CYCLES << ctrl_q.slew;
    assign ramping = ctrl_q.scale_auth && !vsel_q.fb_select && (ramp_q != vsel_q.ref_code);

    always_comb begin
        ctrl_d = ctrl_q;
        vsel_d = vsel_q;
        ramp_d = ramp_q;
        step_cnt_d = step_cnt_q;
        rd_data_d = 8'h00;
        if (!en_on) begin
            ctrl_d = scr_pkg::RESET_SYSTEM_CONTROL_ONE;
            vsel_d = scr_pkg::RESET_VOLTAGE_SELECT;
            ramp_d = scr_pkg::RESET_VOLTAGE_SELECT[6:0];
            step_cnt_d = 12'h000;
        end else begin
            if (ramping) begin
                if (step_cnt_q >= step_len) begin
                    step_cnt_d = 12'h001;
                    ramp_d = (ramp_q < vsel_q.ref_code) ? ramp_q + 7'h01 : ramp_q - 7'h01;
                end else begin
                    step_cnt_d = step_cnt_q + 12'h001;
                end
            end else if (ctrl_q.scale_auth && !vsel_q.fb_select && step_cnt_q != 12'h000) begin
                ctrl_d.scale_auth = 1'b0;
                step_cnt_d = 12'h000;
            end
            if (vsel_q.fb_select) begin
                ramp_d = vsel_q.ref_code;
            end
            if (wr_en && addr == scr_pkg::ADDR_SYSTEM_CONTROL_ONE) begin
                ctrl_d = wr_data;
            end
            if (wr_en && addr == scr_pkg::ADDR_VOLTAGE_SELECT && ctrl_q.scale_auth) begin
                vsel_d = wr_data;
                step_cnt_d = 12'h001;
            end
            if (rd_en) begin
                unique case (addr)
                    scr_pkg::ADDR_VOLTAGE_SELECT: rd_data_d = vsel_q;
                    scr_pkg::ADDR_SYSTEM_CONTROL_ONE: rd_data_d = ctrl_q;
                    default: rd_data_d = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= scr_pkg::RESET_SYSTEM_CONTROL_ONE;
            vsel_q <= scr_pkg::RESET_VOLTAGE_SELECT;
            ramp_q <= scr_pkg::RESET_VOLTAGE_SELECT[6:0];
            step_cnt_q <= 12'h000;
            rd_data <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            vsel_q <= vsel_d;
            ramp_q <= ramp_d;
            step_cnt_q <= step_cnt_d;
            rd_data <= rd_data_d;
        end
    end

    // ************************************************
    // Protection
    // ************************************************
    scr_pkg::scr_prot_type prot_q, prot_d;
    logic [16:0] hic_cnt_q, hic_cnt_d;
    logic ov_stop;

    always_comb begin
        prot_d = prot_q;
        hic_cnt_d = hic_cnt_q;
        unique case (prot_q)
            scr_pkg::SCR_RUN: begin
                if (ov_in && !ctrl_q.ov_retry) begin
                    prot_d = scr_pkg::SCR_LATCHED;
                end else if (oc_in && uv_in) begin
                    hic_cnt_d = 17'h00000;
                    prot_d = ctrl_q.oc_hiccup ? scr_pkg::SCR_HICCUP
                                              : scr_pkg::SCR_LATCHED;
                end
            end
            scr_pkg::SCR_HICCUP: begin
                if (hic_cnt_q == 17'(scr_pkg::HICCUP_OFF_CYCLES - 1)) begin
                    prot_d = scr_pkg::SCR_RUN;
                end else begin
                    hic_cnt_d = hic_cnt_q + 17'h00001;
                end
            end
            scr_pkg::SCR_LATCHED: prot_d = scr_pkg::SCR_LATCHED;
            default: prot_d = scr_pkg::SCR_RUN;
        endcase
        if (!en_on) begin
            prot_d = scr_pkg::SCR_RUN;
            hic_cnt_d = 17'h00000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prot_q <= scr_pkg::SCR_RUN;
            hic_cnt_q <= 17'h00000;
        end else begin
            prot_q <= prot_d;
            hic_cnt_q <= hic_cnt_d;
        end
    end

    assign ov_stop = ov_in && ctrl_q.ov_retry;

    // ************************************************
    // Outputs
    // ************************************************
    logic switch_on;
    assign switch_on = en_on && ctrl_q.run && prot_q == scr_pkg::SCR_RUN && !ov_stop;
    assign high_side_switch = switch_on;
    assign low_side_switch = switch_on;
    assign forced_pwm = ctrl_q.scale_auth || ctrl_q.light_mode;
    assign feedback_from_divider = vsel_q.fb_select;
    assign output_voltage = ramp_q;
    assign bus_active = en_on;
endmodule

// ---- scr_sva.sv ----
// Checker for the system control register block
`timescale 1ns/1ns
module scr_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic enable_pin,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic overvoltage,
    input wire logic overcurrent,
    input wire logic undervoltage,
    input wire logic high_side_switch,
    input wire logic low_side_switch,
    input wire logic forced_pwm,
    input wire logic feedback_from_divider,
    input wire logic [6:0] output_voltage,
    input wire logic bus_active
);
    // ****
    // Ramp step spacing counter, then the property checks
    // ****
    logic [7:0] gap_q, gap_d;
    logic [6:0] vo_q;
    always_comb begin
        gap_d = (output_voltage != vo_q) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
    end
    always_ff @(posedge clk_sys) begin
        gap_q <= rst ? 8'hff : gap_d;
        vo_q <= output_voltage;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence ctl_wr;
        wr_en && bus_active && addr == 8'h01;
    endsequence
    sequence ov_held;
        overvoltage [*4];
    endsequence
    a_run_off:
    assert property (ctl_wr ##0 !wr_data[7] |=> !(high_side_switch | low_side_switch))
        else $error("switching after run cleared");
    a_enable_gate:
    assert property (high_side_switch || low_side_switch |-> bus_active)
        else $error("switching with enable low");
    a_bus_quiet:
    assert property (!bus_active && !$past(bus_active) |-> rd_data == 8'h00)
        else $error("read data with enable low");
    a_mode_pwm:
    assert property (ctl_wr |=> forced_pwm == $past(wr_data[0] | wr_data[6]))
        else $error("forced pwm wrong");
    a_ref_refused:
    assert property (!forced_pwm && wr_en && bus_active && addr == 8'h00
        |=> $stable(feedback_from_divider)) else $error("write taken without authority");
    a_fb_write:
    assert property ($fell(feedback_from_divider) |-> $past(wr_en && addr == 8'h00))
        else $error("feedback source changed alone");
    a_ramp_pwm:
    assert property ($changed(output_voltage) && bus_active && $past(bus_active) |-> forced_pwm)
        else $error("ramp without authority");
    a_slew_gap:
    assert property ($changed(output_voltage) && bus_active && $past(bus_active)
        |-> gap_q >= 8'h08) else $error("ramp steps too close");
    a_ov_off:
    assert property (ov_held |=> !high_side_switch)
        else $error("switching during overvoltage");
endmodule
bind scr_system_control scr_sva scr_sva_i (.*);

// ---- scr_host.sv ----
// Host model for register transfers and the scaling handshake
`timescale 1ns/1ns
module scr_host (
    input wire logic clk_sys,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
    end
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge clk_sys);
        wr_en = w;
        rd_en = !w;
        addr = a;
        wr_data = d;
        @(negedge clk_sys);
        q = rd_data;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = ~a;
        wr_data = ~d;
    endtask
    task automatic scale(input logic [7:0] ctrl, input logic [6:0] code, output int n);
        logic [7:0] q;
        xfer(1'b1, 8'h01, ctrl | 8'h40, q);
        xfer(1'b1, 8'h00, {1'b0, code}, q);
        q = 8'h40;
        for (n = 0; n < 400 && q[6]; n++) xfer(1'b0, 8'h01, 8'h00, q);
    endtask
endmodule

// ---- scr_system_control_tb.sv ----
// Testbench for the system control register block
`timescale 1ns/1ns
module scr_system_control_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic enable_pin = 1'b1;
    logic overvoltage = 1'b0;
    logic overcurrent = 1'b0;
    logic undervoltage = 1'b0;
    logic wr_en, rd_en, rd_pend, bus_active;
    logic high_side_switch, low_side_switch, forced_pwm, feedback_from_divider;
    logic [7:0] addr, wr_data, rd_data, q;
    logic [6:0] output_voltage, code;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int n_checks = 0;
    int n;
    initial forever #25 clk_sys = ~clk_sys;
    scr_system_control scr_system_control_i (.*);
    scr_host scr_host_i (.*);
    task automatic check(input logic [7:0] seen, want);
        n_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        scr_host_i.xfer(1'b0, a, 8'h00, q);
    endtask
    task automatic sw(input logic e);
        check({6'h00, high_side_switch, low_side_switch}, {6'h00, e, e});
    endtask
    always @(posedge clk_sys) rd_pend <= rd_en && bus_active;
    always @(negedge clk_sys) if (rd_pend && exp_q.size() > 0) check(rd_data, exp_q.pop_front());
    initial begin
        void'($urandom(95));
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        rd(8'h01, 8'ha6);
        rd(8'h00, 8'h9e);
        rd(8'h05, 8'h00);
        sw(1'b1);
        scr_host_i.xfer(1'b1, 8'h00, 8'h20, q);
        rd(8'h00, 8'h9e);
        for (int i = 0; i < 2; i++) begin
            code = 7'h1a + 7'($urandom % 8);
            scr_host_i.scale(8'h86, code, n);
            check({7'h00, n < 400}, 8'h01);
            if (n >= 400) stop_test();
            check({1'b0, output_voltage}, {1'b0, code});
            check({6'h00, forced_pwm, feedback_from_divider}, 8'h00);
            rd(8'h01, 8'h86);
        end
        scr_host_i.xfer(1'b1, 8'h01, 8'h07, q);
        sw(1'b0);
        check({7'h00, forced_pwm}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            scr_host_i.xfer(1'b1, 8'h01, i[0] ? (i[1] ? 8'h84 : 8'h82) : 8'h86, q);
            sw(1'b1);
            overvoltage = !i[1];
            overcurrent = i[1];
            undervoltage = i[1];
            repeat (6) @(negedge clk_sys);
            sw(1'b0);
            overvoltage = 1'b0;
            overcurrent = 1'b0;
            undervoltage = 1'b0;
            repeat (2100) @(negedge clk_sys);
            sw(!i[0]);
            enable_pin = 1'b0;
            repeat (4) @(negedge clk_sys);
            check({7'h00, bus_active | high_side_switch}, 8'h00);
            enable_pin = 1'b1;
            repeat (4) @(negedge clk_sys);
            rd(8'h01, 8'ha6);
        end
        repeat (2) @(negedge clk_sys);
        stop_test();
    end
endmodule
